/* File: src/scg_consts.svh */
// register offsets, field positions, reset values, unit count and interrupt bit numbers of the sleep clock gate
`ifndef SCG_CONSTS_SVH
`define SCG_CONSTS_SVH
`define SCG_OFF_RUN_GATE 12'h100
`define SCG_OFF_SLEEP_GATE 12'h110
`define SCG_OFF_DEEP_GATE 12'h120
`define SCG_OFF_RUN_CFG 12'h060
`define SCG_OFF_POWER_STATE 12'h1f0
`define SCG_OFF_INT_STATUS 12'h1f4
`define SCG_OFF_INT_ENABLE 12'h1f8
`define SCG_OFF_INT_CLEAR 12'h1fc
`define SCG_BIT_CAN 24
`define SCG_BIT_WDT 3
`define SCG_BIT_FIXED_ONE 6
`define SCG_BIT_AUTO_GATING 27
`define SCG_GATE_RESET 32'h0000_0040
`define SCG_GATE_RW_MASK 32'h0100_0008
`define SCG_CFG_RESET 32'h0000_0000
`define SCG_NUM_UNITS 2
`define SCG_INT_FAULT_CAN 0
`define SCG_INT_FAULT_WDT 1
`define SCG_INT_STATE_CHG 2
`define SCG_INT_WIDTH 3
`endif

/* File: src/scg_pkg.sv */
// types shared by the sleep clock gate
package scg_pkg;
    typedef enum logic [1:0] {
        SCG_RUN,
        SCG_SLEEP,
        SCG_DEEP_SLEEP
    } scg_power_e;
    typedef enum logic [1:0] {
        SCG_BUS_IDLE,
        SCG_BUS_ACK,
        SCG_BUS_WAIT
    } scg_bus_e;
endpackage

/* File: src/scg_glitchfree_gate.sv */
// glitch-free clock gate for one unit: enable latched while the clock is low
`timescale 1ns/1ps
module scg_glitchfree_gate (
    input wire logic clk,
    input wire logic enable,
    output logic gated_clk
);
    logic en_latched;

    // latch opens only while clk is low so the enable never cuts a high phase
    always_latch begin
        if (!clk) begin
            en_latched <= enable;
        end
    end

    assign gated_clk = clk & en_latched;
endmodule

/* File: src/scg_sleep_clock_gate.sv */
// sleep and deep-sleep unit clock gating with a classic wishbone register slave
//
// Overview of operation
// - set gate bit clocks the unit
// - access to gated unit ends in fault
// - all enable bits reset to zero
// - sleep gate register at 0x110
// - deep-sleep gate register at 0x120
// - sleep registers apply only with auto gating
// - bit 24 gates the can controller
// - bit 3 gates the watchdog
// - gate registers reset 0x40, bit 6 one
// - other reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "scg_consts.svh"
module scg_sleep_clock_gate (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [11:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic WB_ERR_O,
    input wire logic SLEEP_REQ,
    input wire logic DEEP_SLEEP_REQ,
    input wire logic CAN_ACC_REQ,
    input wire logic WDT_ACC_REQ,
    output logic CAN_ACC_FAULT,
    output logic WDT_ACC_FAULT,
    output logic CAN_CLK_EN,
    output logic WDT_CLK_EN,
    output logic CAN_CLK,
    output logic WDT_CLK,
    output logic [1:0] POWER_STATE,
    output logic IRQ
);
    import scg_pkg::*;

    typedef struct packed {
        logic [31:0] run_gate;
        logic [31:0] sleep_gate;
        logic [31:0] deep_gate;
        logic [31:0] run_cfg;
        scg_power_e power;
        logic [`SCG_NUM_UNITS-1:0] unit_en;
        logic [2:0] int_status;
        logic [2:0] int_enable;
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic can_fault;
        logic wdt_fault;
        logic sleep_s1;
        logic sleep_s2;
        logic deep_s1;
        logic deep_s2;
        logic can_req_s1;
        logic can_req_s2;
        logic wdt_req_s1;
        logic wdt_req_s2;
    } scg_state_s;

    scg_state_s st_r;
    scg_state_s st_nxt;

    logic [31:0] wmask;
    logic bus_req;
    logic [31:0] sel_gate;
    logic [`SCG_NUM_UNITS-1:0] gate_bits;
    logic [`SCG_NUM_UNITS-1:0] unit_clk;

    assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    // new request only when no answer is pending, so ack lasts exactly one cycle
    assign bus_req = WB_CYC_I & WB_STB_I & ~st_r.ack & ~st_r.err;

    function automatic logic [31:0] gate_write(input logic [31:0] old, input logic [31:0] d,
                                               input logic [31:0] m);
        logic [31:0] v;
        v = (old & ~m) | (d & m);
        // only the two enables are writable, bit 6 stays one, the rest zero
        gate_write = (v & `SCG_GATE_RW_MASK) | `SCG_GATE_RESET;
    endfunction

    always_comb begin
        st_nxt = st_r;
        sel_gate = st_r.run_gate;
        gate_bits = '0;

        st_nxt.sleep_s1 = SLEEP_REQ;
        st_nxt.sleep_s2 = st_r.sleep_s1;
        st_nxt.deep_s1 = DEEP_SLEEP_REQ;
        st_nxt.deep_s2 = st_r.deep_s1;
        st_nxt.can_req_s1 = CAN_ACC_REQ;
        st_nxt.can_req_s2 = st_r.can_req_s1;
        st_nxt.wdt_req_s1 = WDT_ACC_REQ;
        st_nxt.wdt_req_s2 = st_r.wdt_req_s1;

        // deep sleep wins when both requests are present
        if (st_r.deep_s2) begin
            st_nxt.power = SCG_DEEP_SLEEP;
        end else if (st_r.sleep_s2) begin
            st_nxt.power = SCG_SLEEP;
        end else begin
            st_nxt.power = SCG_RUN;
        end

        // without auto gating the run register keeps control in every state
        if (st_r.run_cfg[`SCG_BIT_AUTO_GATING]) begin
            case (st_r.power)
                SCG_SLEEP: sel_gate = st_r.sleep_gate;
                SCG_DEEP_SLEEP: sel_gate = st_r.deep_gate;
                default: sel_gate = st_r.run_gate;
            endcase
        end
        gate_bits[0] = sel_gate[`SCG_BIT_CAN];
        gate_bits[1] = sel_gate[`SCG_BIT_WDT];
        st_nxt.unit_en = gate_bits;

        // an access to an unclocked unit raises a fault that stays high while the synchronized request is held
        st_nxt.can_fault = st_r.can_req_s2 & ~st_r.unit_en[0];
        st_nxt.wdt_fault = st_r.wdt_req_s2 & ~st_r.unit_en[1];

        st_nxt.ack = 1'b0;
        st_nxt.err = 1'b0;
        if (bus_req) begin
            st_nxt.ack = 1'b1;
            st_nxt.rdata = 32'h0000_0000;
            case (WB_ADR_I)
                `SCG_OFF_RUN_GATE: begin
                    st_nxt.rdata = st_r.run_gate;
                    if (WB_WE_I) st_nxt.run_gate = gate_write(st_r.run_gate, WB_DAT_I, wmask);
                end
                `SCG_OFF_SLEEP_GATE: begin
                    st_nxt.rdata = st_r.sleep_gate;
                    if (WB_WE_I) begin
                        st_nxt.sleep_gate = gate_write(st_r.sleep_gate, WB_DAT_I, wmask);
                    end
                end
                `SCG_OFF_DEEP_GATE: begin
                    st_nxt.rdata = st_r.deep_gate;
                    if (WB_WE_I) begin
                        st_nxt.deep_gate = gate_write(st_r.deep_gate, WB_DAT_I, wmask);
                    end
                end
                `SCG_OFF_RUN_CFG: begin
                    st_nxt.rdata = st_r.run_cfg;
                    if (WB_WE_I) begin
                        st_nxt.run_cfg[`SCG_BIT_AUTO_GATING] =
                            WB_SEL_I[3] ? WB_DAT_I[`SCG_BIT_AUTO_GATING]
                                        : st_r.run_cfg[`SCG_BIT_AUTO_GATING];
                    end
                end
                `SCG_OFF_POWER_STATE: st_nxt.rdata = {30'h0, st_r.power};
                `SCG_OFF_INT_STATUS: st_nxt.rdata = {29'h0, st_r.int_status};
                `SCG_OFF_INT_ENABLE: begin
                    st_nxt.rdata = {29'h0, st_r.int_enable};
                    if (WB_WE_I && WB_SEL_I[0]) st_nxt.int_enable = WB_DAT_I[2:0];
                end
                `SCG_OFF_INT_CLEAR: begin
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        st_nxt.int_status = st_r.int_status & ~WB_DAT_I[2:0];
                    end
                end
                default: begin
                    st_nxt.ack = 1'b0;
                    st_nxt.err = 1'b1;
                end
            endcase
        end

        // hardware events are applied after the clear so a same-cycle set survives
        if (st_nxt.can_fault) st_nxt.int_status[`SCG_INT_FAULT_CAN] = 1'b1;
        if (st_nxt.wdt_fault) st_nxt.int_status[`SCG_INT_FAULT_WDT] = 1'b1;
        if (st_nxt.power != st_r.power) st_nxt.int_status[`SCG_INT_STATE_CHG] = 1'b1;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_r <= '0;
            st_r.run_gate <= `SCG_GATE_RESET;
            st_r.sleep_gate <= `SCG_GATE_RESET;
            st_r.deep_gate <= `SCG_GATE_RESET;
            st_r.run_cfg <= `SCG_CFG_RESET;
            st_r.power <= SCG_RUN;
        end else begin
            st_r <= st_nxt;
        end
    end

    // one gate cell per unit so an enable change never chops a clock pulse
    generate
        for (genvar u = 0; u < `SCG_NUM_UNITS; u++) begin : g_unit
            scg_glitchfree_gate u_gate (
                .clk(CLK),
                .enable(st_r.unit_en[u]),
                .gated_clk(unit_clk[u])
            );
        end
    endgenerate

    assign CAN_CLK = unit_clk[0];
    assign WDT_CLK = unit_clk[1];
    assign CAN_CLK_EN = st_r.unit_en[0];
    assign WDT_CLK_EN = st_r.unit_en[1];
    assign CAN_ACC_FAULT = st_r.can_fault;
    assign WDT_ACC_FAULT = st_r.wdt_fault;
    assign POWER_STATE = st_r.power;
    assign WB_DAT_O = st_r.rdata;
    assign WB_ACK_O = st_r.ack;
    assign WB_ERR_O = st_r.err;
    assign IRQ = |(st_r.int_status & st_r.int_enable);

    property p_gate_reset_value;
        @(posedge CLK) $fell(RESET) |-> st_r.sleep_gate == 32'h0000_0040 &&
            st_r.deep_gate == 32'h0000_0040;
    endproperty
    a_gate_reset_value: assert property (p_gate_reset_value) else $error("gate reset bad");

    property p_fixed_bits;
        @(posedge CLK) disable iff (RESET)
            (st_r.sleep_gate & 32'hfeff_fff7) == 32'h0000_0040 &&
            (st_r.deep_gate & 32'hfeff_fff7) == 32'h0000_0040;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("reserved bits wrong");

    property p_sleep_write;
        @(posedge CLK) disable iff (RESET)
            bus_req && WB_WE_I && WB_ADR_I == 12'h110 && WB_SEL_I == 4'hf
            |=> st_r.sleep_gate == (($past(WB_DAT_I) & 32'h0100_0008) | 32'h0000_0040);
    endproperty
    a_sleep_write: assert property (p_sleep_write) else $error("sleep gate write lost");

    property p_deep_write;
        @(posedge CLK) disable iff (RESET)
            bus_req && WB_WE_I && WB_ADR_I == 12'h120 && WB_SEL_I[3]
            |=> st_r.deep_gate[24] == $past(WB_DAT_I[24]);
    endproperty
    a_deep_write: assert property (p_deep_write) else $error("deep gate write lost");

    property p_can_sleep_select;
        @(posedge CLK) disable iff (RESET)
            st_r.run_cfg[27] && st_r.power == SCG_SLEEP
            |=> CAN_CLK_EN == $past(st_r.sleep_gate[24]);
    endproperty
    a_can_sleep_select: assert property (p_can_sleep_select) else $error("can enable");

    property p_wdt_deep_select;
        @(posedge CLK) disable iff (RESET)
            st_r.run_cfg[27] && st_r.power == SCG_DEEP_SLEEP
            |=> WDT_CLK_EN == $past(st_r.deep_gate[3]);
    endproperty
    a_wdt_deep_select: assert property (p_wdt_deep_select) else $error("wdt enable");

    property p_no_auto_run;
        @(posedge CLK) disable iff (RESET)
            !st_r.run_cfg[27] |=> CAN_CLK_EN == $past(st_r.run_gate[24]);
    endproperty
    a_no_auto_run: assert property (p_no_auto_run) else $error("auto gating ignored");

    property p_fault;
        @(posedge CLK) disable iff (RESET)
            st_r.wdt_req_s2 && !WDT_CLK_EN |=> WDT_ACC_FAULT;
    endproperty
    a_fault: assert property (p_fault) else $error("missing bus fault");

    property p_no_fault_clocked;
        @(posedge CLK) disable iff (RESET) CAN_ACC_FAULT |-> !$past(CAN_CLK_EN);
    endproperty
    a_no_fault_clocked: assert property (p_no_fault_clocked) else $error("false fault");

    property p_ack_one_cycle;
        @(posedge CLK) disable iff (RESET) WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack too long");

    property p_can_deep_select;
        @(posedge CLK) disable iff (RESET)
            st_r.run_cfg[27] && st_r.power == SCG_DEEP_SLEEP
            |=> CAN_CLK_EN == $past(st_r.deep_gate[24]);
    endproperty
    a_can_deep_select: assert property (p_can_deep_select) else $error("can deep");

    property p_wdt_sleep_select;
        @(posedge CLK) disable iff (RESET)
            st_r.run_cfg[27] && st_r.power == SCG_SLEEP
            |=> WDT_CLK_EN == $past(st_r.sleep_gate[3]);
    endproperty
    a_wdt_sleep_select: assert property (p_wdt_sleep_select) else $error("wdt sleep");

    property p_run_select_auto;
        @(posedge CLK) disable iff (RESET)
            st_r.run_cfg[27] && st_r.power == SCG_RUN
            |=> CAN_CLK_EN == $past(st_r.run_gate[24]) &&
                WDT_CLK_EN == $past(st_r.run_gate[3]);
    endproperty
    a_run_select_auto: assert property (p_run_select_auto) else $error("run enable");

    property p_no_auto_wdt;
        @(posedge CLK) disable iff (RESET)
            !st_r.run_cfg[27] |=> WDT_CLK_EN == $past(st_r.run_gate[3]);
    endproperty
    a_no_auto_wdt: assert property (p_no_auto_wdt) else $error("auto gating ignored");

    property p_can_fault;
        @(posedge CLK) disable iff (RESET)
            st_r.can_req_s2 && !CAN_CLK_EN |=> CAN_ACC_FAULT;
    endproperty
    a_can_fault: assert property (p_can_fault) else $error("missing can fault");

    property p_wdt_false_fault;
        @(posedge CLK) disable iff (RESET) WDT_ACC_FAULT |-> !$past(WDT_CLK_EN);
    endproperty
    a_wdt_false_fault: assert property (p_wdt_false_fault) else $error("false fault");

    // the high phase of a unit clock must follow the enable of the edge that opened it
    property p_gated_clock;
        @(negedge CLK) disable iff (RESET)
            CAN_CLK == $past(CAN_CLK_EN) && WDT_CLK == $past(WDT_CLK_EN);
    endproperty
    a_gated_clock: assert property (p_gated_clock) else $error("unit clock");

    property p_enable_reset;
        @(posedge CLK) $fell(RESET) |-> !CAN_CLK_EN && !WDT_CLK_EN;
    endproperty
    a_enable_reset: assert property (p_enable_reset) else $error("enable after reset");

    property p_sleep_read;
        @(posedge CLK) disable iff (RESET)
            bus_req && !WB_WE_I && WB_ADR_I == `SCG_OFF_SLEEP_GATE
            |=> WB_DAT_O == $past(st_r.sleep_gate);
    endproperty
    a_sleep_read: assert property (p_sleep_read) else $error("sleep read");

    property p_deep_read;
        @(posedge CLK) disable iff (RESET)
            bus_req && !WB_WE_I && WB_ADR_I == `SCG_OFF_DEEP_GATE
            |=> WB_DAT_O == $past(st_r.deep_gate);
    endproperty
    a_deep_read: assert property (p_deep_read) else $error("deep read");

    property p_power_deep_wins;
        @(posedge CLK) disable iff (RESET) st_r.deep_s2 |=> POWER_STATE == SCG_DEEP_SLEEP;
    endproperty
    a_power_deep_wins: assert property (p_power_deep_wins) else $error("power state");

    property p_wdt_bit_write;
        @(posedge CLK) disable iff (RESET)
            bus_req && WB_WE_I && WB_ADR_I == `SCG_OFF_SLEEP_GATE && WB_SEL_I[0]
            |=> st_r.sleep_gate[3] == $past(WB_DAT_I[3]);
    endproperty
    a_wdt_bit_write: assert property (p_wdt_bit_write) else $error("wdt write");
endmodule

/* File: testbench/scg_unit_model.sv */
// gated unit model: counts delivered unit clock edges and raises access attempts
`timescale 1ns/1ps
module scg_unit_model (
    input wire logic CAN_CLK,
    input wire logic WDT_CLK,
    input wire logic CAN_TRY,
    input wire logic WDT_TRY,
    output logic CAN_ACC_REQ,
    output logic WDT_ACC_REQ,
    output int can_ticks,
    output int wdt_ticks
);
    // a unit only sees activity while its clock really toggles
    int can_cnt = 0;
    int wdt_cnt = 0;
    always @(posedge CAN_CLK) can_cnt <= can_cnt + 1;
    always @(posedge WDT_CLK) wdt_cnt <= wdt_cnt + 1;
    assign can_ticks = can_cnt;
    assign wdt_ticks = wdt_cnt;
    assign CAN_ACC_REQ = CAN_TRY;
    assign WDT_ACC_REQ = WDT_TRY;
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the sleep clock gate
`timescale 1ns/1ps
`include "scg_consts.svh"
module tb_top;
    import scg_pkg::*;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, slp = 0, dslp = 0, ctry = 0, wtry = 0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rd, dat_o;
    logic ack, err, e, can_flt, wdt_flt, can_en, wdt_en, can_clk, wdt_clk, irq, can_req, wdt_req;
    logic [1:0] pstate;
    logic [11:0] offs [2] = '{`SCG_OFF_SLEEP_GATE, `SCG_OFF_DEEP_GATE};
    int fail_count = 0, checked = 0, cycles = 0, c0, w0, can_ticks, wdt_ticks;
    initial begin
        forever #2.5 clk = ~clk;
    end
    scg_sleep_clock_gate dut (.CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .WB_ERR_O(err), .SLEEP_REQ(slp), .DEEP_SLEEP_REQ(dslp),
        .CAN_ACC_REQ(can_req), .WDT_ACC_REQ(wdt_req), .CAN_ACC_FAULT(can_flt),
        .WDT_ACC_FAULT(wdt_flt), .CAN_CLK_EN(can_en), .WDT_CLK_EN(wdt_en), .CAN_CLK(can_clk),
        .WDT_CLK(wdt_clk), .POWER_STATE(pstate), .IRQ(irq));
    scg_unit_model units (.CAN_CLK(can_clk), .WDT_CLK(wdt_clk), .CAN_TRY(ctry), .WDT_TRY(wtry),
        .CAN_ACC_REQ(can_req), .WDT_ACC_REQ(wdt_req), .can_ticks(can_ticks),
        .wdt_ticks(wdt_ticks));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // holds the request until ack or err is sampled, then releases for one cycle
    // a slave that never answers is caught by the cycle ceiling, not here
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        rd = dat_o;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, e}, 32'h0);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("mismatch at %0t: run did not finish in time", $time);
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(`SCG_OFF_SLEEP_GATE, 32'h0000_0040);
        rdc(`SCG_OFF_DEEP_GATE, 32'h0000_0040);
        chk({30'h0, can_en, wdt_en}, 32'h0);
        wb(1'b0, 12'h200, 32'h0);
        chk({31'h0, e}, 32'h1);
        foreach (offs[i]) begin
            wb(1'b1, offs[i], 32'hffff_ffff);
            rdc(offs[i], 32'h0100_0048);
            wb(1'b1, offs[i], 32'h0000_0000);
            rdc(offs[i], 32'h0000_0040);
        end
        $display("test register_map done");
        rdc(`SCG_OFF_SLEEP_GATE, 32'h0000_0040);
        wb(1'b1, `SCG_OFF_SLEEP_GATE, rd | 32'h0000_0008);
        wb(1'b1, `SCG_OFF_DEEP_GATE, 32'h0100_0040);
        wb(1'b1, `SCG_OFF_RUN_GATE, 32'h0100_0048);
        wb(1'b1, `SCG_OFF_RUN_CFG, 32'h0800_0000);
        rdc(`SCG_OFF_RUN_CFG, 32'h0800_0000);
        chk({30'h0, can_en, wdt_en}, 32'h3);
        slp <= 1'b1;
        repeat (8) @(posedge clk);
        chk({30'h0, pstate}, 32'h1);
        chk({30'h0, can_en, wdt_en}, 32'h1);
        c0 = can_ticks;
        w0 = wdt_ticks;
        repeat (10) @(posedge clk);
        chk({31'h0, can_ticks == c0}, 32'h1);
        chk({31'h0, wdt_ticks > w0}, 32'h1);
        ctry <= 1'b1;
        wtry <= 1'b1;
        repeat (6) @(posedge clk);
        chk({30'h0, can_flt, wdt_flt}, 32'h2);
        wb(1'b1, `SCG_OFF_INT_ENABLE, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rdc(`SCG_OFF_INT_STATUS, 32'h5);
        wb(1'b1, `SCG_OFF_INT_ENABLE, 32'h2);
        chk({31'h0, irq}, 32'h0);
        ctry <= 1'b0;
        wtry <= 1'b0;
        repeat (6) @(posedge clk);
        wb(1'b1, `SCG_OFF_INT_CLEAR, 32'h7);
        wb(1'b1, `SCG_OFF_INT_ENABLE, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("test sleep_state done");
        dslp <= 1'b1;
        wtry <= 1'b1;
        repeat (8) @(posedge clk);
        chk({30'h0, pstate}, 32'h2);
        chk({30'h0, can_en, wdt_en}, 32'h2);
        chk({30'h0, can_flt, wdt_flt}, 32'h1);
        wtry <= 1'b0;
        wb(1'b1, `SCG_OFF_RUN_CFG, 32'h0);
        repeat (8) @(posedge clk);
        chk({30'h0, can_en, wdt_en}, 32'h3);
        $display("test deep_sleep done");
        finish_test();
    end
endmodule
